// *** pkg/mie_consts.svh ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: offsets, reset values and counts of the execute subset
// Assumes: 32-bit avalon-mm slave with byte addresses
// Notes:   definitions only
//////////////////////////////////////////////////////////////////////////////
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

// register byte offsets
`define MIE_OFS_INSTR      8'h00
`define MIE_OFS_WREG       8'h04
`define MIE_OFS_STATUS     8'h08
`define MIE_OFS_PC         8'h0c
`define MIE_OFS_ICTL       8'h10
`define MIE_OFS_MEM_ADDR   8'h14
`define MIE_OFS_MEM_DATA   8'h18
`define MIE_OFS_STACK      8'h1c

// widths and sizes
`define MIE_PC_W           11
`define MIE_MADDR_W        6
`define MIE_MEM_WORDS      64
`define MIE_STACK_DEPTH    6
`define MIE_MC_CLKS        4

// reset values
`define MIE_WREG_RST       8'h00
`define MIE_PC_RST         11'h000
`define MIE_ICTL_RST       8'h00
`define MIE_BYTE_ZERO      8'h00
`define MIE_BYTE_ONE       8'h01
`define MIE_WORD_ZERO      32'h0000_0000

// bit positions
`define MIE_GIE_BIT        0

// machine cycles per instruction class
`define MIE_MC_SHORT       2'h1
`define MIE_MC_LONG        2'h2

`endif

// *** pkg/mie_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: types shared by the execute subset
// Assumes: mie_consts.svh included for widths
// Notes:   opcode numbering is the enum order
//////////////////////////////////////////////////////////////////////////////
`include "mie_consts.svh"

package mie_pkg;

    typedef enum logic [4:0] {
        power_down,
        add_one_to_mem,
        add_one_to_wreg,
        direct_jump,
        copy_mem_to_wreg,
        copy_imm_to_wreg,
        copy_wreg_to_mem,
        idle_instruction,
        union_mem_to_wreg,
        union_imm_to_wreg,
        bitwise_union_to_memory,
        back_from_call,
        back_from_call_imm,
        back_from_interrupt,
        rotate_left,
        rotate_left_to_wreg,
        rotate_left_via_carry,
        rotate_left_via_carry_to_wreg,
        rotate_right,
        rotate_right_to_wreg,
        rotate_right_via_carry,
        rotate_right_via_carry_to_wreg
    } mie_op_t;

    // instruction word as written to the instruction register
    typedef struct packed {
        logic [4:0]              spare_hi;
        logic [`MIE_PC_W-1:0]    operand;
        logic [1:0]              spare_mid;
        logic [`MIE_MADDR_W-1:0] maddr;
        logic [2:0]              spare_lo;
        logic [4:0]              op;
    } mie_instr_t;

    // status flags, low bits of the status register
    typedef struct packed {
        logic halted;
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic zero;
        logic carry;
    } mie_status_t;

    typedef enum logic [1:0] {
        bus_idle,
        bus_exec,
        bus_ack
    } mie_bus_st_t;

endpackage : mie_pkg

// *** rtl/mie_exec_unit.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: execute part of an 8-bit core instruction set over avalon-mm
// Assumes: one clock, async active-high reset, full 32-bit word accesses
// Notes:   writing the instruction register runs one instruction unless halted; the
//          write is held by waitrequest until the instruction retires
//
// Notes on behaviour
// RULE_01 - halt keeping state; set power-down flag, clear timeout; pc plus one
// RULE_02 - memory increment writes byte plus one back to same location
// RULE_03 - increment-to-working loads working register with byte plus one
// RULE_04 - increments and ors touch only zero; via-carry rotates set carry, power-down sets its flags
// RULE_05 - direct jump loads pc with the instruction address field
// RULE_06 - memory-to-working move copies memory byte into working register
// RULE_07 - literal move loads working register with the immediate byte
// RULE_08 - working-to-memory move writes working register into memory
// RULE_09 - idle instruction only advances pc by one
// RULE_10 - memory or puts working or memory into working register
// RULE_11 - literal or puts working or immediate into working register
// RULE_12 - or-to-memory stores working or memory back into memory
// RULE_13 - subroutine return pops pc and takes two machine cycles
// RULE_14 - return-with-literal pops pc and loads immediate into working
// RULE_15 - interrupt return pops pc and sets interrupt enable bit 0
// RULE_16 - rotate left memory, bit 7 into bit 0, written back
// RULE_17 - rotate left into working register, memory unchanged
// RULE_18 - rotate left via carry into memory, old carry to bit 0
// RULE_19 - rotate left via carry into working register, memory unchanged
// RULE_20 - rotate right memory, bit 0 into bit 7, written back
// RULE_21 - rotate right into working register, memory unchanged
// RULE_22 - rotate right via carry into memory, old carry to bit 7
// RULE_23 - rotate right via carry into working register, memory unchanged
//////////////////////////////////////////////////////////////////////////////
`include "mie_consts.svh"

module mie_exec_unit #(
    parameter int MC_CLKS     = `MIE_MC_CLKS,
    parameter int STACK_DEPTH = `MIE_STACK_DEPTH,
    parameter int MEM_WORDS   = `MIE_MEM_WORDS
) (
    input  wire logic        clock,           // 200 mhz core clock
    input  wire logic        rst,             // async reset, active high
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // high until access done
    output logic             halted,          // core in power-down
    output logic             global_interrupt_enable // interrupt enable
);

    localparam int MCW = $clog2(MC_CLKS + 1);
    localparam int SPW = $clog2(STACK_DEPTH + 1);

    //////////////////////////////////////////////////////////////////////////
    // helpers

    // nine-bit rotate: {carry out, byte}
    function automatic logic [8:0] rot(input logic [7:0] b,
                                       input logic       right,
                                       input logic       via_c,
                                       input logic       cin);
        logic fill;
        fill = right ? (via_c ? cin : b[0]) : (via_c ? cin : b[7]);
        if (right)
            rot = {b[0], fill, b[7:1]};
        else
            rot = {b[7], b[6:0], fill};
    endfunction

    function automatic logic is_zero(input logic [7:0] b);
        is_zero = (b == `MIE_BYTE_ZERO);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state

    mie_pkg::mie_bus_st_t   bus_st;
    mie_pkg::mie_instr_t    cur;
    mie_pkg::mie_status_t   flags;
    logic [7:0]             wreg;
    logic [7:0]             ictl;
    logic [`MIE_PC_W-1:0]   pc;
    logic [`MIE_MADDR_W-1:0] mem_ptr;
    logic [7:0]             mem [MEM_WORDS];
    logic [`MIE_PC_W-1:0]   stk [STACK_DEPTH];
    logic [SPW-1:0]         sp;
    logic [MCW-1:0]         mc_cnt;
    logic                   mc_tick;
    logic [1:0]             mc_left;

    logic                   accept;
    logic                   wr_hit;
    logic                   commit;
    logic [31:0]            rd_val;

    // decoded effects of the current instruction
    mie_pkg::mie_op_t       op;
    logic [7:0]             mem_rd;
    logic [7:0]             imm;
    logic [8:0]             rot_res;
    logic                   rot_to_mem;
    logic                   rot_to_wreg;
    logic                   rot_via_c;
    logic                   next_wreg_en;
    logic [7:0]             next_wreg;
    logic                   next_mem_en;
    logic [7:0]             next_mem;
    logic                   next_z_en;
    logic                   next_c_en;
    logic                   next_halt;
    logic                   next_pop;
    logic                   next_jump;
    logic                   next_gie;

    assign accept  = (bus_st == mie_pkg::bus_idle) && (avs_read || avs_write);
    assign wr_hit  = accept && avs_write;
    assign commit  = (bus_st == mie_pkg::bus_exec) && mc_tick
                     && (mc_left == `MIE_MC_SHORT);
    assign op      = mie_pkg::mie_op_t'(cur.op);
    assign mem_rd  = mem[cur.maddr];
    assign imm     = cur.operand[7:0];

    //////////////////////////////////////////////////////////////////////////
    // machine-cycle enable; frozen while halted since the clock is off

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mc_cnt  <= '0;
            mc_tick <= 1'b0;
        end else if (flags.halted) begin
            mc_tick <= 1'b0; // RULE_01
        end else if (mc_cnt == MCW'(MC_CLKS - 1)) begin
            mc_cnt  <= '0;
            mc_tick <= 1'b1;
        end else begin
            mc_cnt  <= mc_cnt + MCW'(1);
            mc_tick <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // decode

    always_comb begin
        rot_to_mem  = 1'b0;
        rot_to_wreg = 1'b0;
        rot_via_c   = 1'b0;
        case (op)
            mie_pkg::rotate_left,
            mie_pkg::rotate_right:           rot_to_mem  = 1'b1;
            mie_pkg::rotate_left_to_wreg,
            mie_pkg::rotate_right_to_wreg:   rot_to_wreg = 1'b1;
            mie_pkg::rotate_left_via_carry,
            mie_pkg::rotate_right_via_carry: begin
                rot_to_mem = 1'b1;
                rot_via_c  = 1'b1;
            end
            mie_pkg::rotate_left_via_carry_to_wreg,
            mie_pkg::rotate_right_via_carry_to_wreg: begin
                rot_to_wreg = 1'b1;
                rot_via_c   = 1'b1;
            end
            default: ;
        endcase
    end

    assign rot_res = rot(mem_rd,
                         op inside {mie_pkg::rotate_right,
                                    mie_pkg::rotate_right_to_wreg,
                                    mie_pkg::rotate_right_via_carry,
                                    mie_pkg::rotate_right_via_carry_to_wreg},
                         rot_via_c, flags.carry);

    always_comb begin
        next_wreg_en = 1'b0;
        next_wreg    = wreg;
        next_mem_en  = 1'b0;
        next_mem     = mem_rd;
        next_z_en    = 1'b0;
        next_c_en    = 1'b0;
        next_halt    = 1'b0;
        next_pop     = 1'b0;
        next_jump    = 1'b0;
        next_gie     = 1'b0;
        case (op)
            mie_pkg::power_down: next_halt = 1'b1; // RULE_01
            mie_pkg::add_one_to_mem: begin
                next_mem_en = 1'b1; // RULE_02
                next_mem    = mem_rd + `MIE_BYTE_ONE;
                next_z_en   = 1'b1; // RULE_04
            end
            mie_pkg::add_one_to_wreg: begin
                next_wreg_en = 1'b1; // RULE_03
                next_wreg    = mem_rd + `MIE_BYTE_ONE;
                next_z_en    = 1'b1; // RULE_04
            end
            mie_pkg::direct_jump: next_jump = 1'b1; // RULE_05
            mie_pkg::copy_mem_to_wreg: begin
                next_wreg_en = 1'b1; // RULE_06
                next_wreg    = mem_rd;
            end
            mie_pkg::copy_imm_to_wreg: begin
                next_wreg_en = 1'b1; // RULE_07
                next_wreg    = imm;
            end
            mie_pkg::copy_wreg_to_mem: begin
                next_mem_en = 1'b1; // RULE_08
                next_mem    = wreg;
            end
            mie_pkg::idle_instruction: ; // RULE_09
            mie_pkg::union_mem_to_wreg: begin
                next_wreg_en = 1'b1; // RULE_10
                next_wreg    = wreg | mem_rd;
                next_z_en    = 1'b1; // RULE_04
            end
            mie_pkg::union_imm_to_wreg: begin
                next_wreg_en = 1'b1; // RULE_11
                next_wreg    = wreg | imm;
                next_z_en    = 1'b1; // RULE_04
            end
            mie_pkg::bitwise_union_to_memory: begin
                next_mem_en = 1'b1; // RULE_12
                next_mem    = wreg | mem_rd;
                next_z_en   = 1'b1; // RULE_04
            end
            mie_pkg::back_from_call: next_pop = 1'b1; // RULE_13
            mie_pkg::back_from_call_imm: begin
                next_pop     = 1'b1; // RULE_14
                next_wreg_en = 1'b1;
                next_wreg    = imm;
            end
            mie_pkg::back_from_interrupt: begin
                next_pop = 1'b1; // RULE_15
                next_gie = 1'b1;
            end
            default: begin
                // rotates; RULE_16 RULE_17 RULE_20 RULE_21 leave carry
                next_mem_en  = rot_to_mem; // RULE_16 RULE_18 RULE_20 RULE_22
                next_mem     = rot_res[7:0];
                next_wreg_en = rot_to_wreg; // RULE_17 RULE_19 RULE_21 RULE_23
                next_wreg    = rot_res[7:0];
                next_c_en    = rot_via_c; // RULE_18 RULE_19 RULE_22 RULE_23
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // bus handshake; waitrequest is dropped for exactly one cycle per access

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_st          <= mie_pkg::bus_idle;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `MIE_WORD_ZERO;
            cur             <= '0;
            mc_left         <= '0;
        end else begin
            case (bus_st)
                mie_pkg::bus_idle: begin
                    if (accept) begin
                        if (avs_read) avs_readdata <= rd_val;
                        if (avs_write && avs_address == `MIE_OFS_INSTR
                            && !flags.halted) begin
                            cur    <= mie_pkg::mie_instr_t'(avs_writedata);
                            bus_st <= mie_pkg::bus_exec;
                            // returns need a second machine cycle
                            if (mie_pkg::mie_op_t'(avs_writedata[4:0]) inside
                                {mie_pkg::back_from_call,
                                 mie_pkg::back_from_call_imm,
                                 mie_pkg::back_from_interrupt})
                                mc_left <= `MIE_MC_LONG; // RULE_13
                            else
                                mc_left <= `MIE_MC_SHORT;
                        end else begin
                            avs_waitrequest <= 1'b0;
                            bus_st          <= mie_pkg::bus_ack;
                        end
                    end
                end
                mie_pkg::bus_exec: begin
                    if (mc_tick) begin
                        if (commit) begin
                            avs_waitrequest <= 1'b0;
                            bus_st          <= mie_pkg::bus_ack;
                        end else begin
                            mc_left <= mc_left - 2'h1;
                        end
                    end
                end
                mie_pkg::bus_ack: begin
                    avs_waitrequest <= 1'b1;
                    bus_st          <= mie_pkg::bus_idle;
                end
                default: bus_st <= mie_pkg::bus_idle;
            endcase
        end
    end

    always_comb begin
        rd_val = `MIE_WORD_ZERO;
        case (avs_address)
            `MIE_OFS_INSTR:    rd_val = 32'(cur);
            `MIE_OFS_WREG:     rd_val = 32'(wreg);
            `MIE_OFS_STATUS:   rd_val = 32'(flags);
            `MIE_OFS_PC:       rd_val = 32'(pc);
            `MIE_OFS_ICTL:     rd_val = 32'(ictl);
            `MIE_OFS_MEM_ADDR: rd_val = 32'(mem_ptr);
            `MIE_OFS_MEM_DATA: rd_val = 32'(mem[mem_ptr]);
            `MIE_OFS_STACK:    rd_val = 32'(sp);
            default:           rd_val = `MIE_WORD_ZERO;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // working register

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            wreg <= `MIE_WREG_RST;
        else if (commit && next_wreg_en)
            wreg <= next_wreg;
        else if (wr_hit && avs_address == `MIE_OFS_WREG)
            wreg <= avs_writedata[7:0];
    end

    //////////////////////////////////////////////////////////////////////////
    // data memory; cleared at reset so reads are never unknown

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < MEM_WORDS; i++)
                mem[i] <= `MIE_BYTE_ZERO;
            mem_ptr <= '0;
        end else begin
            if (commit && next_mem_en)
                mem[cur.maddr] <= next_mem;
            else if (wr_hit && avs_address == `MIE_OFS_MEM_DATA)
                mem[mem_ptr] <= avs_writedata[7:0];
            if (wr_hit && avs_address == `MIE_OFS_MEM_ADDR)
                mem_ptr <= avs_writedata[`MIE_MADDR_W-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status flags; software write is a setup path, halted=0 wakes the core

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (commit) begin
            if (next_halt) begin
                flags.halted                <= 1'b1; // RULE_01
                flags.power_down_flag       <= 1'b1; // RULE_01
                flags.watchdog_timeout_flag <= 1'b0; // RULE_01
            end
            if (next_z_en)
                flags.zero <= is_zero(next_mem_en ? next_mem : next_wreg);
            if (next_c_en)
                flags.carry <= rot_res[8]; // RULE_18 RULE_22
        end else if (wr_hit && avs_address == `MIE_OFS_STATUS) begin
            flags <= mie_pkg::mie_status_t'(avs_writedata[4:0]);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // program counter and return stack

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc <= `MIE_PC_RST;
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stk[i] <= `MIE_PC_RST;
        end else if (commit) begin
            if (next_jump) begin
                pc <= cur.operand; // RULE_05
            end else if (next_pop) begin
                // empty stack returns to address zero
                if (sp != '0) begin
                    pc <= stk[sp - SPW'(1)]; // RULE_13 RULE_14 RULE_15
                    sp <= sp - SPW'(1);
                end else begin
                    pc <= `MIE_PC_RST;
                end
            end else begin
                pc <= pc + `MIE_PC_W'(1); // RULE_01 RULE_09
            end
        end else if (wr_hit && avs_address == `MIE_OFS_PC) begin
            pc <= avs_writedata[`MIE_PC_W-1:0];
        end else if (wr_hit && avs_address == `MIE_OFS_STACK
                     && sp != SPW'(STACK_DEPTH)) begin
            // push for return setup; a full stack drops the write
            stk[sp] <= avs_writedata[`MIE_PC_W-1:0];
            sp      <= sp + SPW'(1);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt control

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            ictl <= `MIE_ICTL_RST;
        else if (commit && next_gie)
            ictl[`MIE_GIE_BIT] <= 1'b1; // RULE_15
        else if (wr_hit && avs_address == `MIE_OFS_ICTL)
            ictl <= avs_writedata[7:0];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            halted                  <= 1'b0;
            global_interrupt_enable <= 1'b0;
        end else begin
            halted                  <= flags.halted;
            global_interrupt_enable <= ictl[`MIE_GIE_BIT];
        end
    end

endmodule // mie_exec_unit

// *** bench/mie_exec_unit_asserts.sv ***
// Purpose: port-level checks of the execute subset
// Assumes: bound into every mie_exec_unit
// Notes:   bounds cover two machine cycles of MC_CLKS clocks plus one clock
`include "mie_consts.svh"
module mie_exec_unit_asserts #(
    parameter int MC_CLKS = 4
) (
    input wire logic        clock,           // clock
    input wire logic        rst,             // reset
    input wire logic [7:0]  avs_address,     // address
    input wire logic        avs_read,        // read
    input wire logic        avs_write,       // write
    input wire logic [31:0] avs_writedata,   // write data
    input wire logic [31:0] avs_readdata,    // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic        halted,          // power-down
    input wire logic        global_interrupt_enable // irq enable
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LAST = 2 * MC_CLKS + 1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence op_req(logic [4:0] code);
        $rose(avs_write) && avs_address == `MIE_OFS_INSTR &&
            avs_writedata[4:0] == code && !halted;
    endsequence
    sequence ack_seen;
        ##[1:LAST] !avs_waitrequest;
    endsequence
    chk_ack_one_cycle: assert property ($fell(avs_waitrequest) |=>
        avs_waitrequest) else $error("ack longer than one cycle");
    chk_ack_has_req: assert property (!avs_waitrequest |->
        (avs_read || avs_write)) else $error("ack without request");
    chk_reg_answer: assert property ($rose(avs_read) |=> !avs_waitrequest)
        else $error("read not answered next cycle");
    chk_instr_bound: assert property ($rose(avs_write) |-> ack_seen)
        else $error("write never answered");
    chk_return_long: assert property (op_req(5'h0b) |->
        avs_waitrequest[*3]) else $error("return answered too soon");
    chk_sleep_halt: assert property (op_req(5'h00) |->
        ack_seen ##2 halted) else $error("power-down did not halt");
    chk_intr_return: assert property (op_req(5'h0d) |->
        ack_seen ##2 global_interrupt_enable) else $error("gie not set");
    chk_halt_cause: assert property ($changed(halted) |->
        $past(avs_write && !avs_waitrequest)) else $error("halted moved");
    chk_gie_cause: assert property ($changed(global_interrupt_enable) |->
        $past(avs_write && !avs_waitrequest)) else $error("gie moved");
    chk_rdata_hold: assert property (avs_waitrequest |->
        $stable(avs_readdata)) else $error("read data changed idle");
endmodule // mie_exec_unit_asserts
//////////////////////////////////////////////////////////////////////////////
bind mie_exec_unit mie_exec_unit_asserts #(.MC_CLKS(MC_CLKS)) u_asserts (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halted(halted),
    .global_interrupt_enable(global_interrupt_enable));

// *** bench/mie_exec_unit_tb_top.sv ***
// Purpose: directed bench of the execute subset over avalon-mm
// Assumes: short machine cycle, data memory address fixed at 5
// Notes:   expectations computed here, never read back from the design
`include "mie_consts.svh"
module mie_exec_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MC = 2;
    localparam logic [7:0] WR = `MIE_OFS_WREG, ST = `MIE_OFS_STATUS;
    localparam logic [7:0] PC = `MIE_OFS_PC, IC = `MIE_OFS_ICTL;
    localparam logic [7:0] MD = `MIE_OFS_MEM_DATA, SK = `MIE_OFS_STACK;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, halted, global_interrupt_enable;
    int          err_count = 0;
    int          n_compared = 0;
    int          lat, cyc = 0;
    always #2.5 clock = ~clock;
    mie_exec_unit #(.MC_CLKS(MC)) u_dut (.clock(clock), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .halted(halted), .global_interrupt_enable(global_interrupt_enable));
    //////////////////////////////////////////////////////////////////////////
    // held until waitrequest low; one idle edge so no double assignment
    task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        lat = 0;
        do begin
            @(posedge clock);
            lat++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(e, q);
    endtask
    task automatic ex(input logic [4:0] op, input logic [10:0] v);
        bus(1'b1, `MIE_OFS_INSTR, {5'h00, v, 2'h0, 6'h05, 3'h0, op});
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_data();
        bus(1'b1, MD, 32'hff);
        ex(5'd1, 11'h0);
        rdc(MD, 32'h00);
        rdc(ST, 32'h02);
        ex(5'd2, 11'h0);
        rdc(WR, 32'h01);
        rdc(MD, 32'h00);
        ex(5'd5, 11'h05a);
        ex(5'd6, 11'h0);
        rdc(MD, 32'h5a);
        bus(1'b1, WR, 32'h0f);
        bus(1'b1, MD, 32'hf0);
        ex(5'd4, 11'h0);
        rdc(WR, 32'hf0);
        rdc(ST, 32'h00);
        ex(5'd9, 11'h00a);
        rdc(WR, 32'hfa);
        bus(1'b1, WR, 32'h00);
        ex(5'd8, 11'h0);
        rdc(WR, 32'hf0);
        bus(1'b1, MD, 32'h05);
        ex(5'd10, 11'h0);
        rdc(MD, 32'hf5);
        $display("test data done");
    endtask
    task automatic t_flow();
        bus(1'b1, PC, 32'h10);
        ex(5'd7, 11'h0);
        rdc(PC, 32'h11);
        ex(5'd3, 11'h7ff);
        rdc(PC, 32'h7ff);
        bus(1'b1, SK, 32'h123);
        ex(5'd11, 11'h0);
        chk(32'h1, 32'(lat > MC + 2));
        rdc(PC, 32'h123);
        bus(1'b1, SK, 32'h055);
        ex(5'd12, 11'h077);
        rdc(PC, 32'h055);
        rdc(WR, 32'h77);
        bus(1'b1, SK, 32'h066);
        ex(5'd13, 11'h0);
        rdc(IC, 32'h01);
        chk(32'h1, 32'(global_interrupt_enable));
        rdc(8'h40, 32'h0);
        $display("test flow done");
    endtask
    task automatic t_rot();
        logic [4:0] op;
        logic       c, rt, via, nc;
        logic [7:0] r;
        for (int i = 0; i < 16; i++) begin
            op = 5'(14 + i / 2);
            c = i[0];
            rt = op >= 5'd18;
            via = op == 5'd16 || op == 5'd17 || op >= 5'd20;
            r = rt ? {via ? c : 1'b1, 7'h25} : {7'h4b, via ? c : 1'b0};
            nc = !via ? c : rt;
            bus(1'b1, ST, {31'h0, c});
            bus(1'b1, WR, 32'h0);
            bus(1'b1, MD, 32'h4b);
            ex(op, 11'h0);
            rdc(MD, {24'h0, op[0] ? 8'h4b : r});
            rdc(WR, {24'h0, op[0] ? r : 8'h00});
            rdc(ST, {31'h0, nc});
        end
        $display("test rotate done");
    endtask
    task automatic t_halt();
        bus(1'b1, ST, 32'h08);
        bus(1'b1, PC, 32'h020);
        ex(5'd0, 11'h0);
        rdc(ST, 32'h14);
        rdc(PC, 32'h021);
        ex(5'd5, 11'h0ee);
        rdc(WR, 32'ha5);
        bus(1'b1, ST, 32'h04);
        chk(32'h0, 32'(halted));
        $display("test halt done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdc(PC, 32'h0);
        bus(1'b1, `MIE_OFS_MEM_ADDR, 32'h05);
        t_data();
        t_flow();
        t_rot();
        t_halt();
        conclude();
    end
endmodule // mie_exec_unit_tb_top
